// File: hdl/sync_pkg.sv
// Package: register map, field layouts, constants and carrier types of the close permit
package sync_pkg;
	// ********************************
	// Register byte offsets
	// ********************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] LEVEL_OFS = 8'h04;
	localparam logic [7:0] VWIN_OFS = 8'h08;
	localparam logic [7:0] FWIN_OFS = 8'h0c;
	localparam logic [7:0] VDIFF_OFS = 8'h10;
	localparam logic [7:0] FDIFF_OFS = 8'h14;
	localparam logic [7:0] ANGLE_OFS = 8'h18;
	localparam logic [7:0] BRKR_OFS = 8'h1c;
	localparam logic [7:0] TIME_OFS = 8'h20;
	localparam logic [7:0] STATUS_OFS = 8'h24;
	// ********************************
	// Control field positions
	// ********************************
	localparam int LIVEBUS_DEADLINE_MODE_BIT = 0;
	localparam int DEADBUS_LIVELINE_MODE_BIT = 1;
	localparam int DDEAD_BIT = 2;
	localparam int SYNC_BIT = 3;
	localparam int LOOP_BIT = 4;
	localparam int FORBID_BIT = 5;
	localparam int PLAIN_BIT = 6;
	localparam int LINE_LL_BIT = 7;
	localparam int PSEL_LSB = 8;
	localparam int HI_LSB = 16;
	// ********************************
	// Reset values
	// ********************************
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] LEVEL_RST = 32'h0bb8_2328; // dead 30 V, live 90 V
	localparam logic [31:0] VWIN_RST = 32'h1644_2710; // under 57 V, over 100 V
	localparam logic [31:0] FWIN_RST = 32'h1388_1770; // under 50 Hz, over 60 Hz
	localparam logic [31:0] VDIFF_RST = 32'h1770_03e8; // sync level 60 V, dv 10 V
	localparam logic [31:0] FDIFF_RST = 32'h0032_0032;
	localparam logic [31:0] ANGLE_RST = 32'h07d0_07d0; // 20 deg both
	localparam logic [31:0] BRKR_RST = 32'h0000_0064; // 100 ms, no offset
	localparam logic [31:0] TIME_RST = 32'h000a_000a; // 10 s, 0.1 Hz
	// ********************************
	// Scaling and timing
	// ********************************
	localparam int SQRT3_NUM = 1732; // 1.732 as a ratio
	localparam int SQRT3_DEN = 1000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
	localparam int MS_PER_S = 1000;
	// ********************************
	// Carrier types
	// ********************************
	typedef struct packed {
		logic [15:0] ua; // Bus phase volts, centivolts
		logic [15:0] ub;
		logic [15:0] uc;
		logic [15:0] uab; // Bus line volts
		logic [15:0] ubc;
		logic [15:0] uca;
		logic [15:0] uline; // Line side volts
		logic [15:0] fbus; // Centihertz
		logic [15:0] fline;
		logic signed [15:0] rate_diff; // Centihertz per second
		logic signed [15:0] angle_diff; // Centidegrees
	} meas_t;
	typedef struct packed {
		logic dead_dead_ok;
		logic deadbus_liveline_ok;
		logic livebus_deadline_ok;
		logic energize_ok;
		logic loop_close_ok;
		logic phase_match_ok;
		logic plain_mode_ok;
	} ok_t;
	typedef struct packed {
		logic voltage_gap_alarm;
		logic frequency_gap_alarm;
		logic angle_gap_alarm;
		logic slip_rate_alarm;
		logic closing_angle_alarm;
		logic unequal_frequency_alarm;
		logic transformer_break_alarm;
		logic sync_voltage_fault_alarm;
		logic sync_frequency_fault_alarm;
	} alarm_t;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_EXPIRED} attempt_t;
endpackage

// File: hdl/slip_angle_predict.sv
// Compensated closing angle error from slip, slip rate and breaker time
`timescale 1ns/100ps
module slip_angle_predict (
	// Measured quantities
	input wire logic signed [16:0] slip_i, // Centihertz
	input wire logic signed [15:0] rate_i, // Centihertz per second
	input wire logic signed [15:0] angle_i, // Centidegrees
	// Settings
	input wire logic [15:0] close_ms_i,
	input wire logic [15:0] inh_angle_i, // Centidegrees
	// Result
	output logic [31:0] error_o // Centidegrees, magnitude
);
	// ********************************
	// Drift prediction
	// ********************************
	logic signed [63:0] t_ms; // Breaker time, widened
	logic signed [63:0] lin; // Slip share of drift
	logic signed [63:0] quad; // Slip-rate share of drift
	logic signed [63:0] drift;
	logic signed [63:0] err;
	// Degrees = 360*f*T; centi-units on f and ms on T fold into /1000
	always_comb begin
		t_ms = 64'(close_ms_i);
		lin = (64'sd360 * 64'(slip_i) * t_ms) / 64'sd1000; // RQ10
		quad = (64'sd180 * 64'(rate_i) * t_ms * t_ms) / 64'sd1000000; // RQ10
		drift = lin + quad - 64'(inh_angle_i); // RQ11
		err = 64'(angle_i) - drift;
		if (err < 0) begin
			err = -err;
		end
		error_o = (err > 64'sh7fff_ffff) ? 32'h7fff_ffff : err[31:0]; // RQ10
	end
endmodule

// File: hdl/synchrocheck_close_permit.sv
// Close permit logic: energizing check, synchronism check and register slave
//
// How it works
// RQ1 - Voltage gap scaled by 1.732 per kinds
// RQ2 - Both sides above sync level, scaled
// RQ3 - Three energizing modes, each separately enabled
// RQ4 - Side above live level counts live
// RQ5 - Side below dead level counts dead
// RQ6 - Bus dead or live needs all phases
// RQ7 - Select codes 0-2 phase, 3-5 line
// RQ8 - Line select: phases against level/1.732; code scales only the dead level, phases meet the live level unscaled
// RQ9 - Sync ok needs all limits together
// RQ10 - Angle error is measured minus predicted drift
// RQ11 - Drift uses breaker time and inherent angle
// RQ12 - Angle judged only with frequencies in window
// RQ13 - Closing angle limit blocks close permission
// RQ14 - Attempt abandoned when process time expires
// RQ15 - Output timed for breaker closing delay
// RQ16 - Outside asserts block, also on break
// RQ17 - Outside asserts start to begin attempt
// RQ18 - One condition-met output per mode
// RQ19 - Alarms for each failed difference limit
// RQ20 - Alarms for frequency, break, voltage, frequency faults
// RQ21 - Block clears all results and alarms
// RQ22 - Overall result when any mode met
// RQ23 - Re-evaluate everything on each sample strobe
// RQ24 - Reset clears outputs, alarms and timer
`timescale 1ns/100ps
module synchrocheck_close_permit import sync_pkg::*; #(
	parameter int MS_CYCLES = MS_CYCLES_DEF // Clock cycles per millisecond
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Control inputs from surrounding logic
	input wire logic function_block_in_i,
	input wire logic attempt_start_cmd_i,
	input wire logic transformer_break_i,
	// Measurements
	input wire logic meas_valid_i,
	input wire meas_t meas_i,
	// Results
	output ok_t ok_o,
	output alarm_t alarm_o,
	output logic sync_result_o
);
	// ********************************
	// Register file
	// ********************************
	logic [31:0] ctrl_reg, level_reg, vwin_reg, fwin_reg, vdiff_reg;
	logic [31:0] fdiff_reg, angle_reg, brkr_reg, time_reg;
	logic wr_pend_reg; // Write data phase pending
	logic [7:0] wr_ofs_reg; // Latched write offset
	logic [31:0] hrdata_reg;
	logic [31:0] status;
	logic addr_ok; // Address phase taken
	ok_t ok_reg;
	alarm_t alm_reg;
	logic result_reg;
	attempt_t state_reg;
	assign addr_ok = hsel_i && htrans_i[1] && hready_i;
	assign status = {22'h0, state_reg, result_reg, ok_reg};

	// Address phase capture of writes
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_pend_reg <= 1'b0;
			wr_ofs_reg <= 8'h00;
		end else begin
			wr_pend_reg <= addr_ok && hwrite_i;
			if (addr_ok) begin
				wr_ofs_reg <= haddr_i[7:0];
			end
		end
	end

	// Data phase writes; read-only and unmapped words ignore them
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_reg <= CTRL_RST;
			level_reg <= LEVEL_RST;
			vwin_reg <= VWIN_RST;
			fwin_reg <= FWIN_RST;
			vdiff_reg <= VDIFF_RST;
			fdiff_reg <= FDIFF_RST;
			angle_reg <= ANGLE_RST;
			brkr_reg <= BRKR_RST;
			time_reg <= TIME_RST;
		end else if (wr_pend_reg) begin
			case (wr_ofs_reg)
				CTRL_OFS: ctrl_reg <= {21'h0, hwdata_i[10:0]};
				LEVEL_OFS: level_reg <= hwdata_i;
				VWIN_OFS: vwin_reg <= hwdata_i;
				FWIN_OFS: fwin_reg <= hwdata_i;
				VDIFF_OFS: vdiff_reg <= hwdata_i;
				FDIFF_OFS: fdiff_reg <= hwdata_i;
				ANGLE_OFS: angle_reg <= hwdata_i;
				BRKR_OFS: brkr_reg <= hwdata_i;
				TIME_OFS: time_reg <= hwdata_i;
				default: ;
			endcase
		end
	end

	// Read data prepared at the address phase so the data phase has no wait
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hrdata_reg <= 32'h0;
		end else if (addr_ok && !hwrite_i) begin
			case (haddr_i[7:0])
				CTRL_OFS: hrdata_reg <= ctrl_reg;
				LEVEL_OFS: hrdata_reg <= level_reg;
				VWIN_OFS: hrdata_reg <= vwin_reg;
				FWIN_OFS: hrdata_reg <= fwin_reg;
				VDIFF_OFS: hrdata_reg <= vdiff_reg;
				FDIFF_OFS: hrdata_reg <= fdiff_reg;
				ANGLE_OFS: hrdata_reg <= angle_reg;
				BRKR_OFS: hrdata_reg <= brkr_reg;
				TIME_OFS: hrdata_reg <= time_reg;
				STATUS_OFS: hrdata_reg <= status;
				default: hrdata_reg <= 32'h0; // Unmapped reads zero
			endcase
		end
	end

	assign hrdata_o = hrdata_reg;

	// Always ready, always OKAY; held in flops so outputs come from registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end

	// ********************************
	// Setting fields
	// ********************************
	logic [2:0] phase_select;
	logic bus_ll, line_ll; // Line-to-line kinds
	logic [15:0] live_threshold, dead_threshold;
	logic [15:0] overvoltage_limit, undervoltage_limit;
	logic [15:0] overfrequency_limit, underfrequency_limit;
	logic [15:0] dv_limit, sync_voltage_threshold;
	logic [15:0] df_limit, dfdt_limit, angle_limit, closing_angle_limit;
	logic [15:0] same_freq_limit, attempt_timeout;

	assign phase_select = ctrl_reg[PSEL_LSB +: 3];
	assign bus_ll = phase_select >= 3'h3; // RQ7
	assign line_ll = ctrl_reg[LINE_LL_BIT];
	assign live_threshold = level_reg[15:0];
	assign dead_threshold = level_reg[HI_LSB +: 16];
	assign overvoltage_limit = vwin_reg[15:0];
	assign undervoltage_limit = vwin_reg[HI_LSB +: 16];
	assign overfrequency_limit = fwin_reg[15:0];
	assign underfrequency_limit = fwin_reg[HI_LSB +: 16];
	assign dv_limit = vdiff_reg[15:0];
	assign sync_voltage_threshold = vdiff_reg[HI_LSB +: 16];
	assign df_limit = fdiff_reg[15:0];
	assign dfdt_limit = fdiff_reg[HI_LSB +: 16];
	assign angle_limit = angle_reg[15:0];
	assign closing_angle_limit = angle_reg[HI_LSB +: 16];
	assign same_freq_limit = time_reg[15:0];
	assign attempt_timeout = time_reg[HI_LSB +: 16];

	// ********************************
	// Measurement judgement
	// ********************************
	// Scale by 1.732 either way; 32 bits keep the product from wrapping
	function automatic logic [31:0] div3(input logic [31:0] x);
		div3 = (x * 32'(SQRT3_DEN)) / 32'(SQRT3_NUM);
	endfunction
	function automatic logic [31:0] mul3(input logic [31:0] x);
		mul3 = (x * 32'(SQRT3_NUM)) / 32'(SQRT3_DEN);
	endfunction

	logic [31:0] u_bus, u_line, ub_n, ul_n, gap_a, gap_b, gap_lim, v_dead;
	logic [31:0] ang_err;
	logic signed [16:0] slip;
	logic [16:0] slip_mag, rate_mag;
	logic bus_dead, bus_live, line_dead, line_live;
	logic v_gap_ok, f_gap_ok, rate_ok, ang_ok, cls_ok, same_ok;
	logic v_win_ok, f_win_ok, lvl_ok;

	// Compared bus voltage from the phase selection
	always_comb begin
		case (phase_select)
			3'h0: u_bus = 32'(meas_i.ua);
			3'h1: u_bus = 32'(meas_i.ub);
			3'h2: u_bus = 32'(meas_i.uc);
			3'h3: u_bus = 32'(meas_i.uab);
			3'h4: u_bus = 32'(meas_i.ubc);
			default: u_bus = 32'(meas_i.uca);
		endcase // RQ7
	end

	assign u_line = 32'(meas_i.uline);
	assign ub_n = bus_ll ? div3(u_bus) : u_bus; // RQ2
	assign ul_n = line_ll ? div3(u_line) : u_line; // RQ2
	assign lvl_ok = ub_n > 32'(sync_voltage_threshold)
		&& ul_n > 32'(sync_voltage_threshold); // RQ2

	// Voltage gap: mixed kinds scale one side, two line kinds scale the limit
	always_comb begin
		gap_a = u_bus;
		gap_b = u_line;
		gap_lim = 32'(dv_limit);
		if (!bus_ll && line_ll) begin
			gap_b = div3(u_line); // RQ1
		end else if (bus_ll && !line_ll) begin
			gap_a = div3(u_bus); // RQ1
		end else if (bus_ll && line_ll) begin
			gap_lim = mul3(32'(dv_limit)); // RQ1
		end
	end
	assign v_gap_ok = ((gap_a > gap_b) ? gap_a - gap_b : gap_b - gap_a) < gap_lim;

	// Phases are phase-to-neutral, so with a line pick the dead level shrinks
	assign v_dead = bus_ll ? div3(32'(dead_threshold)) : 32'(dead_threshold); // RQ8
	assign bus_dead = 32'(meas_i.ua) < v_dead && 32'(meas_i.ub) < v_dead
		&& 32'(meas_i.uc) < v_dead; // RQ6
	assign bus_live = meas_i.ua > live_threshold && meas_i.ub > live_threshold
		&& meas_i.uc > live_threshold; // RQ6
	assign line_dead = meas_i.uline < dead_threshold; // RQ5
	assign line_live = meas_i.uline > live_threshold; // RQ4

	// Frequency and slip tests
	assign slip = 17'(meas_i.fline) - 17'(meas_i.fbus);
	assign slip_mag = slip[16] ? 17'(-slip) : slip;
	assign rate_mag = meas_i.rate_diff[15] ? 17'(-17'(meas_i.rate_diff))
		: 17'(meas_i.rate_diff);
	assign f_gap_ok = slip_mag < 17'(df_limit);
	assign same_ok = slip_mag < 17'(same_freq_limit);
	assign rate_ok = rate_mag < 17'(dfdt_limit);
	assign v_win_ok = u_bus >= 32'(undervoltage_limit) && u_bus <= 32'(overvoltage_limit)
		&& u_line >= 32'(undervoltage_limit) && u_line <= 32'(overvoltage_limit); // RQ9
	assign f_win_ok = meas_i.fbus >= underfrequency_limit && meas_i.fbus <= overfrequency_limit
		&& meas_i.fline >= underfrequency_limit && meas_i.fline <= overfrequency_limit; // RQ9

	// Angle predicted over the breaker time so closure lands on coincidence
	slip_angle_predict u_predict (
		.slip_i(slip),
		.rate_i(meas_i.rate_diff),
		.angle_i(meas_i.angle_diff),
		.close_ms_i(brkr_reg[15:0]),
		.inh_angle_i(brkr_reg[HI_LSB +: 16]),
		.error_o(ang_err)
	); // RQ15

	// Angle only judged with both frequencies inside the window
	assign ang_ok = f_win_ok && ang_err < 32'(angle_limit); // RQ12
	assign cls_ok = f_win_ok && ang_err <= 32'(closing_angle_limit); // RQ13

	// ********************************
	// Attempt sequencing
	// ********************************
	logic [31:0] ms_cnt_reg; // Cycles into current millisecond
	logic [31:0] elapsed_reg; // Milliseconds into the attempt
	logic [31:0] limit_ms;
	assign limit_ms = 32'(attempt_timeout) * 32'(MS_PER_S);

	// Start arms, expiry abandons; a fresh start restarts the window unless block is asserted
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE; // RQ24
		end else if (function_block_in_i) begin
			state_reg <= ST_IDLE; // RQ21
		end else begin
			case (state_reg)
				ST_IDLE, ST_EXPIRED: begin // Expired waits for a fresh start
					if (attempt_start_cmd_i) begin
						state_reg <= ST_RUN; // RQ17
					end
				end
				ST_RUN: begin
					if (!attempt_start_cmd_i && elapsed_reg >= limit_ms) begin
						state_reg <= ST_EXPIRED; // RQ14
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Process timer in milliseconds; cleared at each start and outside a run
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ms_cnt_reg <= 32'h0; // RQ24
			elapsed_reg <= 32'h0;
		end else if (state_reg != ST_RUN || attempt_start_cmd_i) begin
			ms_cnt_reg <= 32'h0; // RQ14
			elapsed_reg <= 32'h0;
		end else if (ms_cnt_reg == 32'(MS_CYCLES - 1)) begin
			ms_cnt_reg <= 32'h0;
			elapsed_reg <= elapsed_reg + 32'h1;
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 32'h1;
		end
	end

	// ********************************
	// Results and alarms
	// ********************************
	ok_t ok_next;
	alarm_t alm_next;
	logic sync_on, loop_on;

	// Sync forbids loop check when both are enabled and the forbid bit is set
	assign sync_on = ctrl_reg[SYNC_BIT];
	assign loop_on = ctrl_reg[LOOP_BIT] && !(sync_on && ctrl_reg[FORBID_BIT]);

	always_comb begin
		ok_next.livebus_deadline_ok = ctrl_reg[LIVEBUS_DEADLINE_MODE_BIT] && bus_live && line_dead; // RQ3
		ok_next.deadbus_liveline_ok = ctrl_reg[DEADBUS_LIVELINE_MODE_BIT] && bus_dead && line_live; // RQ3
		ok_next.dead_dead_ok = ctrl_reg[DDEAD_BIT] && bus_dead && line_dead; // RQ3
		ok_next.energize_ok = ok_next.livebus_deadline_ok
			|| ok_next.deadbus_liveline_ok || ok_next.dead_dead_ok; // RQ18
		ok_next.phase_match_ok = sync_on && lvl_ok && v_gap_ok && f_gap_ok
			&& rate_ok && v_win_ok && f_win_ok && ang_ok && cls_ok; // RQ9
		ok_next.loop_close_ok = loop_on && lvl_ok && v_gap_ok && same_ok
			&& v_win_ok && f_win_ok && ang_ok;
		ok_next.plain_mode_ok = ctrl_reg[PLAIN_BIT];
		alm_next.voltage_gap_alarm = !v_gap_ok; // RQ19
		alm_next.frequency_gap_alarm = !f_gap_ok; // RQ19
		alm_next.angle_gap_alarm = !ang_ok; // RQ19
		alm_next.slip_rate_alarm = !rate_ok; // RQ19
		alm_next.closing_angle_alarm = !cls_ok; // RQ19
		alm_next.unequal_frequency_alarm = !same_ok; // RQ20
		alm_next.transformer_break_alarm = transformer_break_i; // RQ20
		alm_next.sync_voltage_fault_alarm = !v_win_ok || !lvl_ok; // RQ20
		alm_next.sync_frequency_fault_alarm = !f_win_ok; // RQ20
	end

	// Sampled once per strobe; cleared by block, and outside a live attempt
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ok_reg <= '0; // RQ24
			alm_reg <= '0;
			result_reg <= 1'b0;
		end else if (function_block_in_i || state_reg != ST_RUN) begin
			ok_reg <= '0; // RQ21
			alm_reg <= '0;
			result_reg <= 1'b0;
		end else if (meas_valid_i) begin
			ok_reg <= ok_next; // RQ23
			alm_reg <= alm_next;
			result_reg <= ok_next.energize_ok || ok_next.phase_match_ok
				|| ok_next.loop_close_ok || ok_next.plain_mode_ok; // RQ22
		end
	end

	assign ok_o = ok_reg; // RQ18
	assign alarm_o = alm_reg;
	assign sync_result_o = result_reg;
endmodule

// File: dv/synchrocheck_close_permit_monitor.sv
// Checker: port-level properties of the close permit block
`timescale 1ns/100ps
module synchrocheck_close_permit_monitor import sync_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register bus
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	// Control and results
	input wire logic function_block_in_i,
	input wire logic meas_valid_i,
	input wire ok_t ok_o,
	input wire logic sync_result_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Read address phase accepted this edge
	wire rd_take = hsel_i & htrans_i[1] & hready_i & !hwrite_i;
	// ********************************
	// Properties
	// ********************************
	chk_block_clears: assert property (
		function_block_in_i [*3] |-> ok_o == '0 && !sync_result_o)
		else $error("results stand while blocked");
	chk_result_any_ok: assert property (sync_result_o == (|ok_o))
		else $error("overall result differs from mode results");
	chk_ok_needs_strobe: assert property ($rose(|ok_o) |-> $past(meas_valid_i))
		else $error("mode result rose without a sample");
	chk_ready_high: assert property (hreadyout_o)
		else $error("slave inserted a wait state");
	chk_resp_okay: assert property (!hresp_o)
		else $error("slave answered with an error");
	chk_unmapped_zero: assert property (
		rd_take && haddr_i[7:0] > STATUS_OFS |=> hrdata_o == 32'h0)
		else $error("unmapped read gave data");
	chk_ctrl_upper: assert property (
		rd_take && haddr_i[7:0] == CTRL_OFS |=> hrdata_o[31:11] == '0)
		else $error("control upper bits not zero");
	chk_status_mirror: assert property (
		rd_take && haddr_i[7:0] == STATUS_OFS
		|=> hrdata_o[7:0] == {$past(sync_result_o), $past(ok_o)} && hrdata_o[9:8] != 2'b11)
		else $error("status differs from result outputs");
	// Main scenarios reached
	cover property ($rose(ok_o.phase_match_ok));
	cover property ($rose(ok_o.energize_ok));
	cover property (function_block_in_i && ok_o != '0);
endmodule

// File: dv/meas_front.sv
// Measurement front end model: strobed samples toward the permit logic
`timescale 1ns/100ps
module meas_front import sync_pkg::*; (
	// Clock
	input wire logic clk_i,
	// Samples
	output logic meas_valid_o,
	output meas_t meas_o
);
	initial begin
		meas_valid_o = 1'b0;
		meas_o = '0;
	end
	// One-cycle strobe; afterwards the bus carries the inverse, so stale data cannot pass
	task automatic emit(input meas_t m, input int gap);
		meas_valid_o <= 1'b1;
		meas_o <= m;
		@(posedge clk_i);
		meas_valid_o <= 1'b0;
		meas_o <= ~m;
		repeat (gap) @(posedge clk_i);
	endtask
endmodule

// File: dv/synchrocheck_close_permit_tb.sv
// Testbench: register map, energizing, synchronism, block and timeout scenarios
`timescale 1ns/100ps
module synchrocheck_close_permit_tb import sync_pkg::*; ;
	localparam int MSC = 4; // Short millisecond for simulation
	localparam int LIVE = LEVEL_RST[15:0];
	localparam int DEAD = LEVEL_RST[31:16];
	localparam logic [31:0] RST_TAB [10] = '{CTRL_RST, LEVEL_RST, VWIN_RST, FWIN_RST,
		VDIFF_RST, FDIFF_RST, ANGLE_RST, BRKR_RST, TIME_RST, 32'h0};
	// Sync cases: bus volts, line volts, bus freq, line freq, angle
	int sc [6][5] = '{'{10000, 10000, 5000, 5000, 500}, '{10000, 8500, 5000, 5000, 0},
		'{10000, 10000, 5000, 5020, 2500}, '{10000, 10000, 5000, 5000, 2500},
		'{10000, 10000, 4900, 4900, 0}, '{10200, 10200, 5000, 5000, 0}};
	logic clk_i, rst_n_i, hsel, hwrite, hreadyout, hresp, blk, start, brk, mv, res;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd, ct;
	meas_t meas, mm;
	ok_t ok, e;
	alarm_t alarm;
	int n_errors, cmp_count, seed, a, b, c, l, dv, err;
	logic fin, vin;
	synchrocheck_close_permit #(.MS_CYCLES(MSC)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
		.hreadyout_o(hreadyout), .hresp_o(hresp), .function_block_in_i(blk),
		.attempt_start_cmd_i(start), .transformer_break_i(brk), .meas_valid_i(mv),
		.meas_i(meas), .ok_o(ok), .alarm_o(alarm), .sync_result_o(res));
	meas_front u_src (.clk_i(clk_i), .meas_valid_o(mv), .meas_o(meas));
	// ********************************
	// Shared tasks
	// ********************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Bounded wait for the slave's ready at a rising edge
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) begin
			n_errors++;
			give_verdict();
		end
	endtask
	// One single word transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, ad};
		hwrite <= wr;
		htrans <= 2'b10;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask
	function automatic meas_t mk(int ua, int ul, int fb, int fl, int ang);
		meas_t m;
		m = '0;
		m.ua = 16'(ua);
		m.ub = 16'(ua);
		m.uc = 16'(ua);
		m.uline = 16'(ul);
		m.fbus = 16'(fb);
		m.fline = 16'(fl);
		m.angle_diff = 16'(ang);
		return m;
	endfunction
	// Voltage near either threshold band
	function automatic int rv(input logic hi);
		int r;
		r = $random(seed) & 32'h7ff;
		return hi ? 8500 + r : 1400 + r;
	endfunction
	function automatic ok_t energ(input logic [31:0] cv);
		ok_t x;
		int dd;
		logic bl, bd;
		dd = (cv[10:8] >= 3) ? DEAD * 1000 / 1732 : DEAD;
		bl = a > LIVE && b > LIVE && c > LIVE;
		bd = a < dd && b < dd && c < dd;
		x = '0;
		x.livebus_deadline_ok = cv[0] && bl && l < DEAD;
		x.deadbus_liveline_ok = cv[1] && bd && l > LIVE;
		x.dead_dead_ok = cv[2] && bd && l < DEAD;
		x.energize_ok = x.livebus_deadline_ok | x.deadbus_liveline_ok | x.dead_dead_ok;
		x.plain_mode_ok = cv[6];
		return x;
	endfunction
	task automatic pulse_start;
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// ********************************
	// Main sequence
	// ********************************
	initial begin
		seed = 77;
		n_errors = 0;
		cmp_count = 0;
		rst_n_i = 1'b0;
		{hsel, hwrite, blk, start, brk} = '0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// Reset values, unmapped and read-only places
		for (int i = 0; i < 10; i++) begin
			bus(1'b0, 8'(4 * i), 32'h0);
			check(rd, RST_TAB[i]);
		end
		bus(1'b0, 8'h28, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, CTRL_OFS, 32'hffff_ffff);
		bus(1'b0, CTRL_OFS, 32'h0);
		check(rd, 32'h0000_07ff);
		bus(1'b1, STATUS_OFS, 32'hffff_ffff);
		bus(1'b0, STATUS_OFS, 32'h0);
		check(rd, 32'h0);
		$display("Registers test done");
		// Energizing modes with random enables, selects and levels
		pulse_start();
		for (int i = 0; i < 30; i++) begin
			ct = ($random(seed) & 32'h47) | ((($random(seed) & 32'h7fff) % 6) << 8);
			bus(1'b1, CTRL_OFS, ct);
			fin = $random(seed);
			vin = $random(seed);
			a = rv(fin);
			b = rv(fin);
			c = rv(fin);
			l = rv(vin);
			mm = mk(a, l, 5000, 5000, 0);
			mm.ub = 16'(b);
			mm.uc = 16'(c);
			u_src.emit(mm, 1);
			e = energ(ct);
			check({25'h0, ok}, {25'h0, e});
			check(res, |e);
		end
		$display("Energizing test done");
		// Synchronism check limits
		bus(1'b1, CTRL_OFS, 32'h18);
		for (int i = 0; i < 6; i++) begin
			a = sc[i][0];
			l = sc[i][1];
			u_src.emit(mk(a, l, sc[i][2], sc[i][3], sc[i][4]), 1);
			dv = a > l ? a - l : l - a;
			err = sc[i][4] - 360 * (sc[i][3] - sc[i][2]) * 100 / 1000;
			err = err < 0 ? -err : err;
			fin = sc[i][2] >= 5000 && sc[i][2] <= 6000 && sc[i][3] >= 5000 && sc[i][3] <= 6000;
			vin = a >= 5700 && a <= 10000 && l >= 5700 && l <= 10000;
			e = '0;
			c = sc[i][3] - sc[i][2];
			c = c < 0 ? -c : c;
			e.phase_match_ok = dv < 1000 && a > 6000 && l > 6000 && vin && fin && err < 2000
				&& c < 50;
			e.loop_close_ok = e.phase_match_ok && c < 10;
			check({25'h0, ok}, {25'h0, e});
			check(res, e.phase_match_ok | e.loop_close_ok);
			check(alarm.unequal_frequency_alarm, c >= 10);
			check(alarm.sync_voltage_fault_alarm, !vin || a <= 6000 || l <= 6000);
			check(alarm.voltage_gap_alarm, dv >= 1000);
			check(alarm.sync_frequency_fault_alarm, !fin);
			if (fin) begin
				check(alarm.angle_gap_alarm, err >= 2000);
			end
		end
		$display("Synchronism test done");
		// Break flag and block input
		brk <= 1'b1;
		u_src.emit(mk(10000, 10000, 5000, 5000, 0), 1);
		check(alarm.transformer_break_alarm, 1'b1);
		brk <= 1'b0;
		blk <= 1'b1;
		repeat (2) @(posedge clk_i);
		u_src.emit(mk(10000, 10000, 5000, 5000, 0), 1);
		check({ok, res}, 8'h0);
		blk <= 1'b0;
		$display("Block test done");
		// Attempt expires after one second
		bus(1'b1, TIME_OFS, 32'h0001_000a);
		bus(1'b1, CTRL_OFS, 32'h38);
		pulse_start();
		u_src.emit(mk(10000, 10000, 5000, 5000, 0), 1);
		check({ok.loop_close_ok, ok.phase_match_ok}, 2'b01);
		repeat (1000 * MSC + 20) @(posedge clk_i);
		u_src.emit(mk(10000, 10000, 5000, 5000, 0), 1);
		check({ok, res}, 8'h0);
		bus(1'b0, STATUS_OFS, 32'h0);
		check(rd[9:8], 2'd2);
		$display("Timeout test done");
		give_verdict();
	end
endmodule
bind synchrocheck_close_permit synchrocheck_close_permit_monitor u_mon (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .function_block_in_i(function_block_in_i),
	.meas_valid_i(meas_valid_i), .ok_o(ok_o), .sync_result_o(sync_result_o));
